// ==== design/csa_pkg.sv ====
// Constants, types and field layouts for the core store access cycle.
// Assumes a single 20 MHz clock and an active-low asynchronous reset.
//
// Contract
// - The address register is two 9-bit halves, each 8 information bits plus parity, giving 16 address bits.
// - Address weights rise by powers of two from 1 at the low half's bottom bit to 32768 at the high half's top information bit.
// - A location inside the basic 8192-position block is chosen by the low 13 address bits only.
// - The three top address bits extend addressing past the basic block up to 65536 bytes.
// - The address stays stable at the decode for the whole read interval and the whole write interval.
// - A read drives each addressed one-core to zero and its sense pulse sets that bit's data latch.
// - A read of a core already at zero gives no sense pulse and its latch stays cleared.
// - A read clears the location, so the data is kept only by a following write to the same address.
// - A write sets the addressed cores to one; one is the magnetized state and zero the cleared state.
// - An element changes only when both its selection lines are driven together.
// - Each location holds a nine-bit byte, eight information bits and parity, all moved together.
// - During a write each zero data bit asserts its inhibit and each one bit leaves inhibit off.
package csa_pkg;
   localparam int HALF_W      = 9;
   localparam int INFO_W      = 8;
   localparam int ADDR_W      = 16;
   localparam int BASIC_W     = 13;
   localparam int BYTE_W      = 9;
   localparam int MAX_DEPTH   = 65536;
   localparam int CLK_MHZ     = 20;
   localparam int HALF_NS     = 150;
   localparam int HALF_CYC    = (HALF_NS * CLK_MHZ + 999) / 1000;
   localparam logic [3:0] CNT_MAX = 4'(HALF_CYC - 1);

   typedef struct packed {
      logic [HALF_W-1:0] hi;
      logic [HALF_W-1:0] lo;
   } csa_addr_t;

   typedef struct packed {
      logic       valid;
      logic       write;
      csa_addr_t  addr;
      logic [BYTE_W-1:0] wdata;
   } csa_req_t;

   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,
      ST_CLR   = 5'h02,
      ST_READ  = 5'h04,
      ST_WRITE = 5'h08,
      ST_DONE  = 5'h10
   } csa_state_t;
endpackage

// ==== design/csa_core_array.sv ====
// Core plane stack model: nine planes of cells with read and write drive.
// Assumes drive strobes from the cycle sequencer in the same clock domain.
`timescale 1ns/1ns
`default_nettype none
module csa_core_array
   import csa_pkg::*;
#(
   parameter int DEPTH_W = ADDR_W
) (
   input  wire logic              clk,
   input  wire logic [DEPTH_W-1:0] x_sel,
   input  wire logic [DEPTH_W-1:0] y_sel,
   input  wire logic              rd_drive,
   input  wire logic              wr_drive,
   input  wire logic [BYTE_W-1:0] inhibit,
   output logic      [BYTE_W-1:0] sense
);
   if (DEPTH_W < BASIC_W || DEPTH_W > ADDR_W) begin : g_bad_depth
      $error("Store depth outside the supported range");
   end

   // Nine planes share one address, so a whole byte moves at once
   logic [BYTE_W-1:0] cells [0:(1<<DEPTH_W)-1];

   // Both select lines must agree on one cell before it is touched
   wire coincide = (x_sel == y_sel);

   always_ff @(posedge clk) begin
      sense <= '0;
      if (rd_drive && coincide) begin
         sense           <= cells[x_sel];
         cells[x_sel]    <= '0;
      end else if (wr_drive && coincide) begin
         cells[x_sel]    <= cells[x_sel] | ~inhibit;
      end
   end

   AST_SENSE_QUIET: assert property (@(posedge clk)
      !rd_drive |=> sense == '0)
      else $error("Sense output without a read drive");
endmodule // csa_core_array
`default_nettype wire

// ==== design/csa_cycle.sv ====
// Storage cycle sequencer: address register, sense latches, inhibit drive.
// Assumes the processor holds a request until busy and supplies byte data.
`timescale 1ns/1ns
`default_nettype none
module csa_cycle
   import csa_pkg::*;
#(
   parameter int DEPTH_W = ADDR_W
) (
   input  wire logic              clk,
   input  wire logic              rst_b,
   input  wire csa_req_t          req,
   output logic                   busy,
   output logic                   done,
   output logic      [BYTE_W-1:0] rdata,
   output logic      [ADDR_W-1:0] addr_out,
   output logic                   addr_in_range
);
   // Below the basic block the low address bits would not all reach the store
   if (DEPTH_W < BASIC_W || DEPTH_W > ADDR_W) begin : g_bad_depth
      $error("Store depth outside the supported range");
   end

   csa_state_t        state_reg, state_next;
   csa_addr_t         mar_reg, mar_next;
   logic [BYTE_W-1:0] latch_reg, latch_next;
   logic [BYTE_W-1:0] wbuf_reg, wbuf_next;
   logic              wr_new_reg, wr_new_next;
   logic [3:0]        cnt_reg, cnt_next;
   logic              done_reg, done_next;
   logic              rng_reg, rng_next;
   logic [BYTE_W-1:0] sense;
   logic [ADDR_W-1:0] flat_addr;
   logic [DEPTH_W-1:0] cell_addr;
   logic              busy_next;
   logic [ADDR_W-1:0] addr_out_next;

   // Information bits of both halves form the binary address, low half weighs from 1
   assign flat_addr = {mar_reg.hi[INFO_W-1:0], mar_reg.lo[INFO_W-1:0]};
   assign cell_addr = flat_addr[DEPTH_W-1:0];

   wire rd_drv = (state_reg == ST_READ) && (cnt_reg == CNT_MAX);
   wire wr_drv = (state_reg == ST_WRITE) && (cnt_reg == CNT_MAX);
   // Zero data bits inhibit, one bits let the cell set
   wire [BYTE_W-1:0] inh;
   for (genvar i = 0; i < BYTE_W; i++) begin : g_inh
      assign inh[i] = ~wbuf_reg[i];

      AST_INH_BIT: assert property (@(posedge clk) disable iff (!rst_b)
         (wr_drv && !wr_new_reg) |-> inh[i] == ~latch_reg[i])
         else $error("Restore inhibit bit differs from sensed bit");
   end

   csa_core_array #(.DEPTH_W(DEPTH_W)) u_array (
      .clk      (clk),
      .x_sel    (cell_addr),
      .y_sel    (cell_addr),
      .rd_drive (rd_drv),
      .wr_drive (wr_drv),
      .inhibit  (inh),
      .sense    (sense)
   );

   always_comb begin
      state_next  = state_reg;
      mar_next    = mar_reg;
      latch_next  = latch_reg;
      wbuf_next   = wbuf_reg;
      wr_new_next = wr_new_reg;
      cnt_next    = cnt_reg;
      done_next   = 1'b0;
      rng_next    = rng_reg;
      case (state_reg)
         ST_IDLE: begin
            if (req.valid) begin
               mar_next    = req.addr;
               wr_new_next = req.write;
               wbuf_next   = req.wdata;
               state_next  = ST_CLR;
            end
         end
         ST_CLR: begin
            latch_next = '0;
            rng_next   = (DEPTH_W == ADDR_W) || (flat_addr >> DEPTH_W) == '0;
            cnt_next   = '0;
            state_next = ST_READ;
         end
         ST_READ: begin
            // Address held unchanged for the full half; no load path here
            cnt_next = cnt_reg + 4'h1;
            if (cnt_reg == CNT_MAX) begin
               cnt_next = '0;
               state_next = ST_WRITE;
            end
         end
         ST_WRITE: begin
            if (cnt_reg == '0) begin
               latch_next = latch_reg | sense;
               // Restore sensed data unless new data was supplied
               if (!wr_new_reg) wbuf_next = latch_reg | sense;
            end
            cnt_next = cnt_reg + 4'h1;
            if (cnt_reg == CNT_MAX) state_next = ST_DONE;
         end
         ST_DONE: begin
            done_next  = 1'b1;
            state_next = ST_IDLE;
         end
         default: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg  <= ST_IDLE;
         mar_reg    <= '0;
         latch_reg  <= '0;
         wbuf_reg   <= '0;
         wr_new_reg <= 1'b0;
         cnt_reg    <= '0;
         done_reg   <= 1'b0;
         rng_reg    <= 1'b1;
      end else begin
         state_reg  <= state_next;
         mar_reg    <= mar_next;
         latch_reg  <= latch_next;
         wbuf_reg   <= wbuf_next;
         wr_new_reg <= wr_new_next;
         cnt_reg    <= cnt_next;
         done_reg   <= done_next;
         rng_reg    <= rng_next;
      end
   end

   // Registered so the processor never sees a decode glitch on busy or the address
   always_comb begin
      busy_next     = (state_next != ST_IDLE);
      addr_out_next = {mar_next.hi[INFO_W-1:0], mar_next.lo[INFO_W-1:0]};
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         busy     <= 1'b0;
         addr_out <= '0;
      end else begin
         busy     <= busy_next;
         addr_out <= addr_out_next;
      end
   end
   assign done          = done_reg;
   assign rdata         = latch_reg;
   assign addr_in_range = rng_reg;

   // The cycle has a fixed length, so done is checked at a fixed cycle count after the write drive
   AST_ADDR_HELD: assert property (@(posedge clk) disable iff (!rst_b)
      (state_reg == ST_READ || state_reg == ST_WRITE) |=> $stable(mar_reg))
      else $error("Address moved during cycle");

   AST_CNT_BOUND: assert property (@(posedge clk) disable iff (!rst_b)
      (state_reg == ST_READ || state_reg == ST_WRITE) |-> cnt_reg <= CNT_MAX)
      else $error("Half counter past its end");

   AST_MAR_LOAD: assert property (@(posedge clk) disable iff (!rst_b)
      (state_reg == ST_IDLE && req.valid) |=> mar_reg == $past(req.addr))
      else $error("Address register not loaded from request");

   AST_WDATA_TAKE: assert property (@(posedge clk) disable iff (!rst_b)
      (state_reg == ST_IDLE && req.valid) |=> wbuf_reg == $past(req.wdata))
      else $error("Write byte not taken whole");

   AST_TAKE_CLR: assert property (@(posedge clk) disable iff (!rst_b)
      (state_reg == ST_IDLE && req.valid) |=> state_reg == ST_CLR)
      else $error("Request not followed by latch clear");

   AST_LATCH_CLR: assert property (@(posedge clk) disable iff (!rst_b)
      state_reg == ST_CLR |=> latch_reg == '0)
      else $error("Latches not cleared before read");

   // Restore cycles only: the store has no reset, so a first read may sense unknowns
   AST_LATCH_SENSE: assert property (@(posedge clk) disable iff (!rst_b)
      (state_reg == ST_WRITE && cnt_reg == '0 && !wr_new_reg) |=> latch_reg == $past(sense))
      else $error("Latches differ from current sense");

   AST_READ_THEN_WRITE: assert property (@(posedge clk) disable iff (!rst_b)
      rd_drv |=> state_reg == ST_WRITE ##[1:16] wr_drv)
      else $error("Read half not followed by write half");

   AST_DONE_AFTER: assert property (@(posedge clk) disable iff (!rst_b)
      wr_drv |-> ##2 done_reg)
      else $error("Done late");

   AST_DONE_PULSE: assert property (@(posedge clk) disable iff (!rst_b)
      done_reg |=> !done_reg)
      else $error("Done longer than one cycle");

   AST_BUSY_STATE: assert property (@(posedge clk) disable iff (!rst_b)
      busy == (state_reg != ST_IDLE))
      else $error("Busy disagrees with cycle state");

   AST_ONE_HOT: assert property (@(posedge clk) disable iff (!rst_b)
      $onehot(state_reg))
      else $error("Cycle state not one-hot");

   AST_RESTORE: assert property (@(posedge clk) disable iff (!rst_b)
      (state_reg == ST_WRITE && cnt_reg == '0 && !wr_new_reg) |=> wbuf_reg == latch_reg)
      else $error("Restore data differs from sensed");

   AST_INHIBIT: assert property (@(posedge clk) disable iff (!rst_b)
      wr_drv |-> inh == ~(wr_new_reg ? wbuf_reg : latch_reg))
      else $error("Inhibit wrong");

   AST_NO_DUAL: assert property (@(posedge clk) disable iff (!rst_b)
      !(rd_drv && wr_drv))
      else $error("Read and write drive together");

   AST_RANGE: assert property (@(posedge clk) disable iff (!rst_b)
      state_reg == ST_READ |-> rng_reg == (DEPTH_W == ADDR_W || flat_addr < (1 << DEPTH_W)))
      else $error("Range flag wrong");

   AST_ADDR_MAP: assert property (@(posedge clk) disable iff (!rst_b)
      done_reg |-> addr_out ==
         16'(mar_reg.hi[INFO_W-1:0]) * 16'h0100 + 16'(mar_reg.lo[INFO_W-1:0]))
      else $error("Address weighting wrong");
endmodule // csa_cycle
`default_nettype wire

// ==== bench/csa_proc_model.sv ====
// Processor data flow model: raises a storage request and holds it.
// Assumes start pulses from the bench and busy, done from the cycle unit.
`timescale 1ns/1ns
`default_nettype none
module csa_proc_model
   import csa_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst_b,
   input  wire logic              start,
   input  wire logic              wr,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [BYTE_W-1:0] wdata,
   input  wire logic              busy,
   input  wire logic              done,
   output var  csa_req_t          req
);
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         req <= '0;
      end else if (start) begin
         req.valid   <= 1'b1;
         req.write   <= wr;                            // Zero asks for a restore
         req.addr.hi <= {~^addr[15:8], addr[15:8]};
         req.addr.lo <= {~^addr[7:0], addr[7:0]};
         req.wdata   <= wdata;
      end else if (done) begin
         // Released lines invert so that a late sample cannot pass by luck
         req.addr  <= ~req.addr;
         req.wdata <= ~req.wdata;
      end else if (req.valid && busy) begin
         req.valid <= 1'b0;                            // Address held until done
      end
   end
endmodule // csa_proc_model
`default_nettype wire

// ==== bench/tb_top.sv ====
// Self-checking bench for the storage cycle unit.
// Assumes the processor model drives the request port.
`timescale 1ns/1ns
`default_nettype none
module tb_top
   import csa_pkg::*;
;
   // One cycle for the model to register the start strobe, then the storage cycle
   localparam int LAT = 1 + 3 + 2 * HALF_CYC;
   localparam int BUSY_LEN = 2 + 2 * HALF_CYC;
   logic clk, rst_b, start, wr, busy, done, addr_in_range;
   logic [15:0] addr, addr_out;
   logic [8:0]  wdata, rdata;
   csa_req_t    req;
   int          err_total, comparisons;

   always #25 clk = ~clk;

   // Small store keeps the behavioural array cheap
   csa_cycle #(.DEPTH_W(13)) uut (.clk(clk), .rst_b(rst_b), .req(req), .busy(busy),
      .done(done), .rdata(rdata), .addr_out(addr_out), .addr_in_range(addr_in_range));
   csa_proc_model proc (.clk(clk), .rst_b(rst_b), .start(start), .wr(wr), .addr(addr),
      .wdata(wdata), .busy(busy), .done(done), .req(req));

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic access(input logic w, input logic [15:0] a, input logic [8:0] d,
                         input logic ck, input logic [8:0] exp_r);
      int n;
      int nb;
      @(posedge clk);
      start <= 1'b1;
      wr    <= w;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
      start <= 1'b0;
      n = 0;
      nb = 0;
      while (done !== 1'b1 && n < 40) begin
         @(negedge clk);
         n++;
         if (busy === 1'b1) begin
            nb++;
         end
      end
      chk(16'(n), 16'(LAT));
      chk(16'(nb), 16'(BUSY_LEN));
      chk(addr_out, a);
      chk({15'h0, addr_in_range}, {15'h0, a[15:13] == 3'h0});
      if (ck) chk({7'h0, rdata}, {7'h0, exp_r});
   endtask

   task automatic t_reset;
      @(negedge clk);
      chk({13'h0, busy, done, addr_in_range}, 16'h0001);
      chk({7'h0, rdata}, 16'h0000);
      chk(addr_out, 16'h0000);
      $display("test reset done");
   endtask

   task automatic t_rw;
      access(1'b1, 16'h0a5c, 9'h1a5, 1'b0, 9'h000);
      access(1'b0, 16'h0a5c, 9'h000, 1'b1, 9'h1a5);
      access(1'b0, 16'h0a5c, 9'h000, 1'b1, 9'h1a5);
      access(1'b1, 16'h0a5c, 9'h05a, 1'b1, 9'h1a5);
      access(1'b0, 16'h0a5c, 9'h000, 1'b1, 9'h05a);
      access(1'b1, 16'h0a5c, 9'h000, 1'b1, 9'h05a);
      access(1'b0, 16'h0a5c, 9'h000, 1'b1, 9'h000);
      $display("test read write done");
   endtask

   task automatic t_addr;
      access(1'b1, 16'h1fff, 9'h0ff, 1'b0, 9'h000);
      access(1'b1, 16'hf123, 9'h133, 1'b0, 9'h000);
      access(1'b0, 16'h1123, 9'h000, 1'b1, 9'h133);
      access(1'b1, 16'h8001, 9'h100, 1'b0, 9'h000);
      access(1'b0, 16'h0001, 9'h000, 1'b1, 9'h100);
      access(1'b0, 16'h0a5c, 9'h000, 1'b1, 9'h000);
      access(1'b0, 16'h1fff, 9'h000, 1'b1, 9'h0ff);
      $display("test addressing done");
   endtask

   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      rst_b = 1'b0;
      start = 1'b0;
      wr = 1'b0;
      addr = 16'h0000;
      wdata = 9'h000;
      err_total = 0;
      comparisons = 0;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      t_reset;
      t_rw;
      t_addr;
      finish_test;
   end

   // About 160 cycles are needed; a hang is cut well after that
   initial begin
      #(50 * 1000);
      err_total++;
      finish_test;
   end
endmodule // tb_top
`default_nettype wire
